// *** rtl/slc_defines.vh ***
`ifndef SLC_DEFINES_VH
`define SLC_DEFINES_VH

// Sleep mode encodings.
`define SLC_MODE_IDLE       1'b0
`define SLC_MODE_PDOWN      1'b1

// Power states.
`define SLC_ST_RUN          2'b00
`define SLC_ST_IDLE         2'b01
`define SLC_ST_PDOWN        2'b10
`define SLC_ST_WAKE         2'b11

// Port width and reset pulse timing.
`define SLC_IO_WIDTH        5
`define SLC_RST_MIN_NS      50
`define SLC_CLK_PERIOD_NS   20
`define SLC_RST_MIN_CYC     ((`SLC_RST_MIN_NS + `SLC_CLK_PERIOD_NS - 1) / `SLC_CLK_PERIOD_NS)

// Oscillator restart settle time in cycles.
`define SLC_OSC_START_CYC   16

`endif

// *** rtl/slc_io_port.v ***
`timescale 1ns/10ps
`include "slc_defines.vh"

// ----------------------------------------------------------------
// Per-bit port cell: output, direction and pull-up per pin.
// ----------------------------------------------------------------
module slc_io_port #(
    parameter WIDTH = `SLC_IO_WIDTH
) (
    input  wire             i_clk,
    input  wire             i_hiz,
    input  wire [WIDTH-1:0] i_out,
    input  wire [WIDTH-1:0] i_dir,
    input  wire [WIDTH-1:0] i_pull,
    input  wire [WIDTH-1:0] i_pin,
    output wire [WIDTH-1:0] o_pin,
    output wire [WIDTH-1:0] o_pin_oe_n,
    output wire [WIDTH-1:0] o_pull_en,
    output wire [WIDTH-1:0] o_in
);

    reg [WIDTH-1:0] oe_n_r;
    reg [WIDTH-1:0] out_r;
    reg [WIDTH-1:0] pull_r;
    reg [WIDTH-1:0] in_r;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            always @(posedge i_clk) begin
                oe_n_r[g] <= i_hiz | ~i_dir[g];
                out_r[g]  <= i_out[g];
                pull_r[g] <= ~i_hiz & ~i_dir[g] & i_pull[g];
                in_r[g]   <= i_pin[g];
            end
        end
    endgenerate

    assign o_pin      = out_r;
    assign o_pin_oe_n = oe_n_r;
    assign o_pull_en  = pull_r;
    assign o_in       = in_r;

endmodule

// *** rtl/slc_sleep_ctrl.v ***
`timescale 1ns/10ps
`include "slc_defines.vh"

module slc_sleep_ctrl #(
    parameter IO_WIDTH  = `SLC_IO_WIDTH,
    parameter OSC_START = `SLC_OSC_START_CYC
) (
    input  wire                i_clk,
    input  wire                i_reset,
    input  wire                i_reset_n_pin,
    input  wire                i_sleep_req,
    input  wire                i_sleep_mode,
    input  wire                i_irq,
    input  wire [IO_WIDTH-1:0] i_io_out,
    input  wire [IO_WIDTH-1:0] i_io_dir,
    input  wire [IO_WIDTH-1:0] i_io_pull,
    input  wire [IO_WIDTH-1:0] i_general_io_pins,
    output reg                 o_osc_en,
    output reg                 o_cpu_clk_en,
    output reg                 o_periph_clk_en,
    output reg                 o_core_reset,
    output reg  [1:0]          o_power_state,
    output wire [IO_WIDTH-1:0] o_general_io_pins,
    output wire [IO_WIDTH-1:0] o_general_io_pins_oe_n,
    output wire [IO_WIDTH-1:0] o_io_pull_en,
    output wire [IO_WIDTH-1:0] o_io_in
);

    // ----------------------------------------------------------------
    // Timing constants
    // ----------------------------------------------------------------
    // Counts are held at 32 bits and cut on purpose to the counter widths.
    localparam [31:0] RST_STRETCH_W = `SLC_RST_MIN_CYC;
    localparam [31:0] OSC_START_W   = OSC_START;
    localparam [2:0]  RST_STRETCH   = RST_STRETCH_W[2:0];
    localparam [15:0] OSC_RELOAD    = OSC_START_W[15:0];

    // ----------------------------------------------------------------
    // Reset capture
    // ----------------------------------------------------------------
    // The latch is set without a clock so a short low pulse is kept
    // until the clocked logic has seen it. After a pin pulse the clear is a one-cycle pulse;
    // a low level that lasts to the next edge is still seen through the pin.
    // Synchronous reset also clears the latch, so it never starts unknown.
    reg       pin_rst_latch_r;
    reg       pin_rst_clr_r;
    reg [2:0] rst_cnt_r;
    reg [2:0] rst_cnt_nxt;
    reg       any_reset_r;
    reg       any_reset_nxt;
    reg       pin_rst_clr_nxt;

    always @(negedge i_reset_n_pin or posedge pin_rst_clr_r) begin
        if (pin_rst_clr_r) begin
            pin_rst_latch_r <= 1'b0;
        end else begin
            pin_rst_latch_r <= 1'b1;
        end
    end

    always @* begin
        rst_cnt_nxt     = rst_cnt_r;
        pin_rst_clr_nxt = pin_rst_latch_r & i_reset_n_pin;
        any_reset_nxt   = pin_rst_latch_r | ~i_reset_n_pin | (rst_cnt_r != 3'h0);
        if (pin_rst_latch_r || !i_reset_n_pin) begin
            rst_cnt_nxt = RST_STRETCH;
        end else if (rst_cnt_r != 3'h0) begin
            rst_cnt_nxt = rst_cnt_r - 3'h1;
        end
    end

    always @(posedge i_clk) begin
        if (i_reset) begin
            rst_cnt_r     <= 3'h0;
            pin_rst_clr_r <= 1'b1;
            any_reset_r   <= 1'b1;
        end else begin
            rst_cnt_r     <= rst_cnt_nxt;
            pin_rst_clr_r <= pin_rst_clr_nxt;
            any_reset_r   <= any_reset_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Power state machine
    // ----------------------------------------------------------------
    // On an interrupt, power-down leaves through WAKE so the core only runs again once the
    // restarted oscillator has had its settle time; a reset goes straight to RUN.
    localparam ST_RUN   = `SLC_ST_RUN;
    localparam ST_IDLE  = `SLC_ST_IDLE;
    localparam ST_PDOWN = `SLC_ST_PDOWN;
    localparam ST_WAKE  = `SLC_ST_WAKE;

    reg [1:0]  state_r;
    reg [1:0]  state_nxt;
    reg [15:0] osc_cnt_r;
    reg [15:0] osc_cnt_nxt;
    wire       rst_all = i_reset | any_reset_r;

    always @* begin
        state_nxt   = state_r;
        osc_cnt_nxt = osc_cnt_r;
        case (state_r)
            ST_RUN: begin
                if (i_sleep_req) begin
                    if (i_sleep_mode == `SLC_MODE_PDOWN) begin
                        state_nxt = ST_PDOWN;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_IDLE: begin
                if (i_irq) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_PDOWN: begin
                if (i_irq) begin
                    state_nxt   = ST_WAKE;
                    osc_cnt_nxt = OSC_RELOAD;
                end
            end
            ST_WAKE: begin
                if (osc_cnt_r <= 16'h0001) begin
                    state_nxt   = ST_RUN;
                    osc_cnt_nxt = 16'h0000;
                end else begin
                    osc_cnt_nxt = osc_cnt_r - 16'h0001;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Enable decode
    // ----------------------------------------------------------------
    // Decoding from the next state keeps the registered enables in step
    // with state_r, so no enable lags the state it belongs to.
    reg osc_en_nxt;
    reg cpu_clk_en_nxt;
    reg periph_clk_en_nxt;

    always @* begin
        osc_en_nxt        = 1'b1;
        cpu_clk_en_nxt    = 1'b0;
        periph_clk_en_nxt = 1'b0;
        case (state_nxt)
            ST_RUN: begin
                cpu_clk_en_nxt    = 1'b1;
                periph_clk_en_nxt = 1'b1;
            end
            ST_IDLE: begin
                periph_clk_en_nxt = 1'b1;
            end
            ST_PDOWN: begin
                osc_en_nxt        = 1'b0;
            end
            ST_WAKE: begin
                osc_en_nxt        = 1'b1;
            end
            default: begin
                osc_en_nxt        = 1'b1;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State and output registers
    // ----------------------------------------------------------------
    always @(posedge i_clk) begin
        if (rst_all) begin
            state_r   <= ST_RUN;
            osc_cnt_r <= 16'h0000;
        end else begin
            state_r   <= state_nxt;
            osc_cnt_r <= osc_cnt_nxt;
        end
    end

    always @(posedge i_clk) begin
        if (rst_all) begin
            o_osc_en        <= 1'b1;
            o_cpu_clk_en    <= 1'b0;
            o_periph_clk_en <= 1'b0;
            o_core_reset    <= 1'b1;
            o_power_state   <= ST_RUN;
        end else begin
            o_osc_en        <= osc_en_nxt;
            o_cpu_clk_en    <= cpu_clk_en_nxt;
            o_periph_clk_en <= periph_clk_en_nxt;
            o_core_reset    <= 1'b0;
            o_power_state   <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // General I/O port
    // ----------------------------------------------------------------
    slc_io_port #(
        .WIDTH (IO_WIDTH)
    ) u_port (
        .i_clk      (i_clk),
        .i_hiz      (rst_all),
        .i_out      (i_io_out),
        .i_dir      (i_io_dir),
        .i_pull     (i_io_pull),
        .i_pin      (i_general_io_pins),
        .o_pin      (o_general_io_pins),
        .o_pin_oe_n (o_general_io_pins_oe_n),
        .o_pull_en  (o_io_pull_en),
        .o_in       (o_io_in)
    );

endmodule

// *** bench/slc_sleep_ctrl_assertions.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Checks on the power states, wake paths and port release.
// ----------------------------------------------------------------
module slc_sleep_ctrl_assertions #(
    parameter IO_WIDTH = 5
) (
    input wire                i_clk,
    input wire                i_reset,
    input wire                i_reset_n_pin,
    input wire                i_sleep_req,
    input wire                i_sleep_mode,
    input wire                i_irq,
    input wire                o_osc_en,
    input wire                o_cpu_clk_en,
    input wire                o_periph_clk_en,
    input wire                o_core_reset,
    input wire [1:0]          o_power_state,
    input wire [IO_WIDTH-1:0] o_general_io_pins_oe_n,
    input wire [IO_WIDTH-1:0] o_io_pull_en
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence run_ok_s; o_power_state == 2'h0 && !o_core_reset && i_reset_n_pin; endsequence
    sequence wake_s; o_power_state == 2'h3 && o_osc_en ##[1:40] o_power_state == 2'h0 && o_cpu_clk_en; endsequence
    cpu_run_only_a: assert property (o_cpu_clk_en |-> o_power_state == 2'h0) else $error("core runs in sleep");
    osc_pdown_only_a: assert property (!o_osc_en |-> o_power_state == 2'h2) else $error("oscillator off");
    idle_enter_a: assert property (run_ok_s and i_sleep_req && !i_sleep_mode
        |=> o_power_state == 2'h1 && o_periph_clk_en && !o_cpu_clk_en) else $error("idle entry wrong");
    pdown_enter_a: assert property (run_ok_s and i_sleep_req && i_sleep_mode
        |=> o_power_state == 2'h2 && !o_periph_clk_en && !o_osc_en) else $error("power-down entry wrong");
    pdown_wake_a: assert property (o_power_state == 2'h2 && i_irq && i_reset_n_pin |=> wake_s)
        else $error("power-down wake wrong");
    idle_wake_a: assert property (o_power_state == 2'h1 && i_irq && i_reset_n_pin
        |=> o_power_state == 2'h0 && o_cpu_clk_en) else $error("idle wake wrong");
    pin_reset_a: assert property ($fell(i_reset_n_pin) |-> ##[0:3] o_core_reset) else $error("pin reset lost");
    port_hiz_a: assert property (!i_reset_n_pin ##1 !i_reset_n_pin |=>
        &o_general_io_pins_oe_n && o_io_pull_en == 0) else $error("port driven in reset");
endmodule
bind slc_sleep_ctrl slc_sleep_ctrl_assertions #(.IO_WIDTH(IO_WIDTH)) chk_u (.i_clk, .i_reset, .i_reset_n_pin,
    .i_sleep_req, .i_sleep_mode, .i_irq, .o_osc_en, .o_cpu_clk_en, .o_periph_clk_en, .o_core_reset,
    .o_power_state, .o_general_io_pins_oe_n, .o_io_pull_en);

// *** bench/slc_core_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Core side: launches sleep requests and interrupts on falling edges.
// ----------------------------------------------------------------
module slc_core_model (
    input  wire i_clk,
    input  wire i_go,
    input  wire i_mode,
    input  wire i_wake,
    output reg  o_sleep_req,
    output reg  o_sleep_mode,
    output reg  o_irq
);
    initial {o_sleep_req, o_sleep_mode, o_irq} = 3'h0;
    always @(negedge i_clk) begin
        o_sleep_req  <= i_go;
        o_sleep_mode <= i_mode;
        o_irq        <= i_wake;
    end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    logic       i_clk = 1'b0, i_reset = 1'b1, pin_n = 1'b1, go = 1'b0, mode = 1'b0, wake = 1'b0;
    logic       req, smode, irq, osc, cpu, per, crst;
    logic [1:0] st;
    logic [4:0] io_out = 5'h15, io_dir = 5'h1F, io_pull = 5'h1F, pins = 5'h13, po, oe_n, pull_en, io_in;
    logic [5:0] rows [3] = '{6'h0B, 6'h30, 6'h30};
    int         n_mismatch = 0, checks = 0, cyc = 0, i, k;
    initial forever #10 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            end_of_test;
        end
    end
    slc_core_model core_u (.i_clk(i_clk), .i_go(go), .i_mode(mode), .i_wake(wake), .o_sleep_req(req),
        .o_sleep_mode(smode), .o_irq(irq));
    slc_sleep_ctrl #(.OSC_START(2)) dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_reset_n_pin(pin_n),
        .i_sleep_req(req), .i_sleep_mode(smode), .i_irq(irq), .i_io_out(io_out), .i_io_dir(io_dir),
        .i_io_pull(io_pull), .i_general_io_pins(pins), .o_osc_en(osc), .o_cpu_clk_en(cpu), .o_periph_clk_en(per),
        .o_core_reset(crst), .o_power_state(st), .o_general_io_pins(po), .o_general_io_pins_oe_n(oe_n),
        .o_io_pull_en(pull_en), .o_io_in(io_in));
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("Counts: checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge i_clk);
        chk({st, cpu, per, osc, crst}, 16'h0003);
        chk({oe_n, pull_en}, 16'h03E0);
        i_reset = 1'b0;
        repeat (4) @(negedge i_clk);
        chk({st, cpu, per, osc, crst}, 16'h000E);
        chk({oe_n, pull_en}, 16'h0000);
        $display("reset test done");
        for (i = 0; i < 3; i++) begin
            @(posedge i_clk) #1 go = 1'b1;
            mode = rows[i][5];
            @(posedge i_clk) #1 go = 1'b0;
            chk({st, cpu, per, osc}, rows[i][4:0]);
            repeat (5) @(posedge i_clk);
            #1 chk({st, cpu, per, osc}, rows[i][4:0]);
            wake = 1'b1;
            for (k = 0; k < 40 && st !== 2'h0; k++) @(posedge i_clk) #1;
            wake = 1'b0;
            chk({st, cpu, per, osc}, 16'h0007);
            $display("sleep row %0d done", i);
        end
        @(negedge i_clk) io_dir = 5'h0A;
        repeat (3) @(negedge i_clk);
        chk({oe_n, pull_en, io_in}, 16'h56B3);
        chk(po, 16'h0015);
        @(negedge i_clk) io_pull = 5'h0D;
        repeat (2) @(negedge i_clk);
        chk({oe_n, pull_en, io_in}, 16'h54B3);
        @(posedge i_clk) #3 pin_n = 1'b0;
        #55 pin_n = 1'b1;
        chk({crst, oe_n}, 16'h003F);
        repeat (10) @(posedge i_clk);
        #1 chk({crst, oe_n, st}, 16'h0054);
        $display("port and pin reset test done");
        end_of_test;
    end
endmodule
